/* ics_pkg.sv */
/*
 * Shared constants and types of the instruction cycle sequencer: opcode
 * classes, machine cycle kinds, micro-operations, the microcode word and the
 * fixed addresses and offsets used by the datapath.
 * Assumes a 16-bit byte-addressed memory with word-aligned instructions.
 */
package ics_pkg;

   // ***************************************************************
   // widths and timing
   // ***************************************************************
   localparam int WORD_W = 16;
   localparam int STEP_W = 5;
   localparam int CLOCKS_PER_MC = 2;
   localparam logic [15:0] PC_STEP = 16'h0002;

   // ***************************************************************
   // reset and vector addresses (plain defaults, arbitrary)
   // ***************************************************************
   localparam logic [15:0] PC_RESET = 16'h0100;
   localparam logic [15:0] WP_RESET = 16'h0800;
   localparam logic [15:0] ST_RESET = 16'h0000;
   localparam logic [15:0] INT_VEC_PC = 16'h0004;
   localparam logic [15:0] XOP_VEC_BASE = 16'h0040;

   // ***************************************************************
   // context save offsets from the new workspace pointer
   // ***************************************************************
   localparam logic [15:0] CTX_R11_OFS = 16'h0016;
   localparam logic [15:0] CTX_R13_OFS = 16'h001A;
   localparam logic [15:0] CTX_R14_OFS = 16'h001C;
   localparam logic [15:0] CTX_R15_OFS = 16'h001E;

   // ***************************************************************
   // opcode matching, register addressing only
   // ***************************************************************
   localparam logic [15:0] OPM_ADD = 16'hFC30;
   localparam logic [15:0] OPC_ADD = 16'hA000;
   localparam logic [15:0] OPM_ONE = 16'hFFF0;
   localparam logic [15:0] OPC_ABS = 16'h0740;
   localparam logic [15:0] OPC_CONTEXT_SWITCH_BRANCH_OP = 16'h0400;
   localparam logic [15:0] OPM_XOP = 16'hFC30;
   localparam logic [15:0] OPC_XOP = 16'h2C00;
   localparam int SRC_LSB = 0;
   localparam int DST_LSB = 6;
   localparam int ST_CARRY = 12;
   localparam int ST_ZERO = 13;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [2:0] {CL_NOP, CL_ADD, CL_ABS, CL_CONTEXT_SWITCH_BRANCH_OP, CL_XOP} ics_class_t;
   typedef enum logic [1:0] {MC_READ, MC_ALU, MC_WRITE} ics_kind_t;
   typedef enum logic [4:0] {
      U_FETCH, U_DECODE, U_SRC_ADDR, U_DST_ADDR, U_LD_T1, U_LD_S, U_ADD, U_NEG,
      U_IDLE, U_INC_MAR, U_VEC_ADDR, U_CTX_R11, U_CTX_R13, U_CTX_R14, U_CTX_R15,
      U_SWITCH, U_STORE
   } ics_uop_t;
   typedef enum logic {ST_EXEC, ST_INTR} ics_state_t;

   typedef struct packed {
      ics_kind_t kind;
      ics_uop_t op;
      logic last;
      logic adv;
   } ics_uword_t;

endpackage : ics_pkg

/* ics_ucode_if.sv */
/*
 * Link between the cycle engine and the microcode store.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/1ps
interface ics_ucode_if;
   ics_pkg::ics_class_t cls;
   logic [ics_pkg::STEP_W-1:0] step;
   logic msb;
   ics_pkg::ics_uword_t uw;

   modport seq (output cls, output step, output msb, input uw);
   modport rom (input cls, input step, input msb, output uw);
endinterface : ics_ucode_if

/* ics_ucode_rom.sv */
/*
 * Microcode store: per opcode class and step, the machine cycle kind, the
 * micro-operation, the end-of-instruction mark and the pc advance mark.
 * Assumes the engine holds step stable through a machine cycle; during the fetch the class follows the bus word.
 */
`timescale 1ns/1ps
module ics_ucode_rom (
   ics_ucode_if.rom u
);

   function automatic ics_pkg::ics_uword_t mk(input ics_pkg::ics_kind_t k,
      input ics_pkg::ics_uop_t o, input logic l, input logic a);
      ics_pkg::ics_uword_t w;
      w.kind = k;
      w.op = o;
      w.last = l;
      w.adv = a;
      return w;
   endfunction : mk

   localparam ics_pkg::ics_kind_t R = ics_pkg::MC_READ;
   localparam ics_pkg::ics_kind_t A = ics_pkg::MC_ALU;
   localparam ics_pkg::ics_kind_t W = ics_pkg::MC_WRITE;

   always_comb begin
      u.uw = mk(A, ics_pkg::U_IDLE, 1'b1, 1'b0);
      if (u.step == '0) begin
         u.uw = mk(R, ics_pkg::U_FETCH, 1'b0, u.cls == ics_pkg::CL_NOP);
      end else if (u.step == 5'd1) begin
         unique case (u.cls)
            ics_pkg::CL_NOP: u.uw = mk(A, ics_pkg::U_DECODE, 1'b1, 1'b0);
            ics_pkg::CL_XOP, ics_pkg::CL_CONTEXT_SWITCH_BRANCH_OP, ics_pkg::CL_ABS, ics_pkg::CL_ADD:
               u.uw = mk(A, ics_pkg::U_SRC_ADDR, 1'b0, 1'b0);
         endcase
      end else begin
         unique case (u.cls)
            ics_pkg::CL_ADD: begin
               // read, alu, read, alu, write after fetch and decode
               unique case (u.step)
                  5'd2: u.uw = mk(R, ics_pkg::U_LD_T1, 1'b0, 1'b0);
                  5'd3: u.uw = mk(A, ics_pkg::U_DST_ADDR, 1'b0, 1'b0);
                  5'd4: u.uw = mk(R, ics_pkg::U_LD_S, 1'b0, 1'b0);
                  5'd5: u.uw = mk(A, ics_pkg::U_ADD, 1'b0, 1'b0);
                  default: u.uw = mk(W, ics_pkg::U_STORE, 1'b1, 1'b1);
               endcase
            end
            ics_pkg::CL_ABS: begin
               // a clear sign ends after six machine cycles with no write
               unique case (u.step)
                  5'd2: u.uw = mk(R, ics_pkg::U_LD_S, 1'b0, !u.msb);
                  5'd3: u.uw = mk(A, ics_pkg::U_IDLE, 1'b0, 1'b0);
                  5'd4: u.uw = mk(A, ics_pkg::U_NEG, 1'b0, 1'b0);
                  5'd5: u.uw = mk(A, ics_pkg::U_IDLE, !u.msb, 1'b0);
                  default: u.uw = mk(W, ics_pkg::U_STORE, 1'b1, 1'b1);
               endcase
            end
            ics_pkg::CL_CONTEXT_SWITCH_BRANCH_OP: begin
               unique case (u.step)
                  5'd2: u.uw = mk(R, ics_pkg::U_LD_T1, 1'b0, 1'b0);
                  5'd3: u.uw = mk(A, ics_pkg::U_INC_MAR, 1'b0, 1'b0);
                  5'd4: u.uw = mk(R, ics_pkg::U_LD_S, 1'b0, 1'b0);
                  5'd5: u.uw = mk(A, ics_pkg::U_CTX_R13, 1'b0, 1'b0);
                  5'd7: u.uw = mk(A, ics_pkg::U_CTX_R14, 1'b0, 1'b0);
                  5'd9: u.uw = mk(A, ics_pkg::U_CTX_R15, 1'b0, 1'b0);
                  5'd11: u.uw = mk(A, ics_pkg::U_SWITCH, 1'b0, 1'b0);
                  5'd12: u.uw = mk(A, ics_pkg::U_IDLE, 1'b1, 1'b0);
                  default: u.uw = mk(W, ics_pkg::U_STORE, 1'b0, 1'b0);
               endcase
            end
            ics_pkg::CL_XOP: begin
               unique case (u.step)
                  5'd2: u.uw = mk(R, ics_pkg::U_LD_S, 1'b0, 1'b0);
                  5'd3: u.uw = mk(A, ics_pkg::U_VEC_ADDR, 1'b0, 1'b0);
                  5'd4: u.uw = mk(R, ics_pkg::U_LD_T1, 1'b0, 1'b0);
                  5'd5: u.uw = mk(A, ics_pkg::U_INC_MAR, 1'b0, 1'b0);
                  5'd6: u.uw = mk(R, ics_pkg::U_LD_S, 1'b0, 1'b0);
                  5'd7: u.uw = mk(A, ics_pkg::U_CTX_R11, 1'b0, 1'b0);
                  5'd9: u.uw = mk(A, ics_pkg::U_CTX_R13, 1'b0, 1'b0);
                  5'd11: u.uw = mk(A, ics_pkg::U_CTX_R14, 1'b0, 1'b0);
                  5'd13: u.uw = mk(A, ics_pkg::U_CTX_R15, 1'b0, 1'b0);
                  5'd15: u.uw = mk(A, ics_pkg::U_SWITCH, 1'b0, 1'b0);
                  5'd16: u.uw = mk(A, ics_pkg::U_IDLE, 1'b0, 1'b0);
                  5'd17: u.uw = mk(A, ics_pkg::U_IDLE, 1'b1, 1'b0);
                  default: u.uw = mk(W, ics_pkg::U_STORE, 1'b0, 1'b0);
               endcase
            end
            default: u.uw = mk(A, ics_pkg::U_IDLE, 1'b1, 1'b0);
         endcase
      end
   end

endmodule : ics_ucode_rom

/* ics_sequencer.sv */
/*
 * Machine cycle sequencer: fetches instruction words, steps the microcode
 * store and drives the external memory bus, at least two clocks per machine cycle.
 * Assumes memory answers by raising ready and holding read data until the
 * cycle ends; ready and interrupt request are asynchronous pins, read data is
 * only sampled at the end of a cycle that the synchronised ready has closed.
 */
`timescale 1ns/1ps

module ics_sequencer (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_mem_ready,
   input wire logic [15:0] i_mem_rdata,
   input wire logic i_int_req,
   output logic [15:0] o_mem_addr,
   output logic [15:0] o_mem_wdata,
   output logic o_data_oe,
   output logic o_mem_en,
   output logic o_mem_we,
   output logic o_dbin,
   output logic o_iaq,
   output logic o_instr_done,
   output logic o_int_enter,
   output logic [3:0] o_clk_phase
);

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic rdy_s1_reg;
   logic rdy_s2_reg;
   logic irq_s1_reg;
   logic irq_s2_reg;

   // read data skips the synchroniser: two more flops would leave it a clock
   // late for a two-clock cycle; it is taken only when the synchronised ready
   // closes the cycle, by which time the bus has long settled

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdy_s1_reg <= 1'b0;
         rdy_s2_reg <= 1'b0;
         irq_s1_reg <= 1'b0;
         irq_s2_reg <= 1'b0;
      end else begin
         rdy_s1_reg <= i_mem_ready;
         rdy_s2_reg <= rdy_s1_reg;
         irq_s1_reg <= i_int_req;
         irq_s2_reg <= irq_s1_reg;
      end
   end

   // ***************************************************************
   // four-phase clock
   // ***************************************************************
   logic [1:0] ph_reg;
   logic [1:0] ph_next;

   always_comb begin
      ph_next = ph_reg + 2'h1;
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ph_reg <= 2'h0;
      end else begin
         ph_reg <= ph_next;
      end
   end

   assign o_clk_phase = 4'h1 << ph_reg;

   // ***************************************************************
   // decode and microcode
   // ***************************************************************
   function automatic ics_pkg::ics_class_t f_decode(input logic [15:0] w);
      ics_pkg::ics_class_t c;
      c = ics_pkg::CL_NOP;
      if ((w & ics_pkg::OPM_ADD) == ics_pkg::OPC_ADD) begin
         c = ics_pkg::CL_ADD;
      end else if ((w & ics_pkg::OPM_ONE) == ics_pkg::OPC_ABS) begin
         c = ics_pkg::CL_ABS;
      end else if ((w & ics_pkg::OPM_ONE) == ics_pkg::OPC_CONTEXT_SWITCH_BRANCH_OP) begin
         c = ics_pkg::CL_CONTEXT_SWITCH_BRANCH_OP;
      end else if ((w & ics_pkg::OPM_XOP) == ics_pkg::OPC_XOP) begin
         c = ics_pkg::CL_XOP;
      end
      return c;
   endfunction : f_decode

   ics_pkg::ics_state_t state_reg;
   ics_pkg::ics_state_t state_next;
   logic [ics_pkg::STEP_W-1:0] step_reg;
   logic [ics_pkg::STEP_W-1:0] step_next;
   logic half_reg;
   logic half_next;
   logic [15:0] pc_reg;
   logic [15:0] pc_next;
   logic [15:0] wp_reg;
   logic [15:0] wp_next;
   logic [15:0] mar_reg;
   logic [15:0] mar_next;
   logic [15:0] ir_reg;
   logic [15:0] ir_next;
   logic [15:0] t1_reg;
   logic [15:0] t1_next;
   logic [15:0] s_reg;
   logic [15:0] s_next;
   logic [15:0] dbus_reg;
   logic [15:0] dbus_next;
   logic [15:0] ea_reg;
   logic [15:0] ea_next;
   logic [15:0] st_reg;
   logic [15:0] st_next;
   logic done_reg;
   logic done_next;
   logic inte_reg;
   logic inte_next;

   ics_ucode_if ucode ();

   ics_ucode_rom u_rom (
      .u (ucode.rom)
   );

   // during the fetch the class comes straight from the incoming word so a
   // no-operand instruction can advance pc at the end of its only read
   assign ucode.cls = f_decode((step_reg == '0) ? i_mem_rdata : ir_reg);
   assign ucode.step = step_reg;
   // the sign of an abs operand comes off the bus while it is being read
   assign ucode.msb = (step_reg == 5'd2) ? i_mem_rdata[15] : s_reg[15];

   logic is_mem;
   logic mc_end;
   logic [16:0] sum;
   logic [15:0] src_addr;
   logic [15:0] dst_addr;

   assign is_mem = (state_reg == ics_pkg::ST_EXEC) && (ucode.uw.kind != ics_pkg::MC_ALU);
   assign mc_end = half_reg && (!is_mem || rdy_s2_reg);
   assign sum = {1'b0, t1_reg} + {1'b0, s_reg};
   assign src_addr = wp_reg + {11'h000, ir_reg[ics_pkg::SRC_LSB +: 4], 1'b0};
   assign dst_addr = wp_reg + {11'h000, ir_reg[ics_pkg::DST_LSB +: 4], 1'b0};

   // ***************************************************************
   // cycle engine and datapath
   // ***************************************************************
   always_comb begin
      state_next = state_reg;
      step_next = step_reg;
      pc_next = pc_reg;
      wp_next = wp_reg;
      mar_next = mar_reg;
      ir_next = ir_reg;
      t1_next = t1_reg;
      s_next = s_reg;
      dbus_next = dbus_reg;
      ea_next = ea_reg;
      st_next = st_reg;
      done_next = 1'b0;
      inte_next = 1'b0;
      // a memory cycle holds its second clock until ready is seen
      half_next = half_reg ? !mc_end : 1'b1;
      if (mc_end && state_reg == ics_pkg::ST_INTR) begin
         pc_next = ics_pkg::INT_VEC_PC;
         mar_next = ics_pkg::INT_VEC_PC;
         inte_next = 1'b1;
         state_next = ics_pkg::ST_EXEC;
      end else if (mc_end) begin
         unique case (ucode.uw.op)
            ics_pkg::U_FETCH: ir_next = i_mem_rdata;
            ics_pkg::U_SRC_ADDR: begin
               mar_next = src_addr;
               ea_next = src_addr;
            end
            ics_pkg::U_DST_ADDR: mar_next = dst_addr;
            ics_pkg::U_LD_T1: t1_next = i_mem_rdata;
            ics_pkg::U_LD_S: s_next = i_mem_rdata;
            ics_pkg::U_ADD: begin
               // mar is left alone so the write reuses the operand address
               s_next = sum[15:0];
               dbus_next = sum[15:0];
               st_next[ics_pkg::ST_CARRY] = sum[16];
               st_next[ics_pkg::ST_ZERO] = (sum[15:0] == 16'h0000);
            end
            ics_pkg::U_NEG: begin
               // s keeps the operand so its sign still decides whether a write follows
               dbus_next = 16'h0000 - s_reg;
            end
            ics_pkg::U_INC_MAR: mar_next = mar_reg + ics_pkg::PC_STEP;
            ics_pkg::U_VEC_ADDR:
               mar_next = ics_pkg::XOP_VEC_BASE + {10'h000, ir_reg[ics_pkg::DST_LSB +: 4], 2'b00};
            ics_pkg::U_CTX_R11: begin
               mar_next = t1_reg + ics_pkg::CTX_R11_OFS;
               dbus_next = ea_reg;
            end
            ics_pkg::U_CTX_R13: begin
               mar_next = t1_reg + ics_pkg::CTX_R13_OFS;
               dbus_next = wp_reg;
            end
            ics_pkg::U_CTX_R14: begin
               // the saved return points past the switching instruction
               mar_next = t1_reg + ics_pkg::CTX_R14_OFS;
               dbus_next = pc_reg + ics_pkg::PC_STEP;
            end
            ics_pkg::U_CTX_R15: begin
               mar_next = t1_reg + ics_pkg::CTX_R15_OFS;
               dbus_next = st_reg;
            end
            ics_pkg::U_SWITCH: begin
               wp_next = t1_reg;
               pc_next = s_reg;
            end
            ics_pkg::U_DECODE, ics_pkg::U_IDLE, ics_pkg::U_STORE: begin
            end
         endcase
         if (ucode.uw.adv) begin
            pc_next = pc_reg + ics_pkg::PC_STEP;
         end
         if (ucode.uw.last) begin
            step_next = '0;
            done_next = 1'b1;
            if (irq_s2_reg) begin
               state_next = ics_pkg::ST_INTR;
            end else begin
               mar_next = pc_next;
            end
         end else begin
            step_next = step_reg + 5'd1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ics_pkg::ST_EXEC;
         step_reg <= '0;
         half_reg <= 1'b0;
         pc_reg <= ics_pkg::PC_RESET;
         wp_reg <= ics_pkg::WP_RESET;
         mar_reg <= ics_pkg::PC_RESET;
         ir_reg <= 16'h0000;
         t1_reg <= 16'h0000;
         s_reg <= 16'h0000;
         dbus_reg <= 16'h0000;
         ea_reg <= 16'h0000;
         st_reg <= ics_pkg::ST_RESET;
         done_reg <= 1'b0;
         inte_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         step_reg <= step_next;
         half_reg <= half_next;
         pc_reg <= pc_next;
         wp_reg <= wp_next;
         mar_reg <= mar_next;
         ir_reg <= ir_next;
         t1_reg <= t1_next;
         s_reg <= s_next;
         dbus_reg <= dbus_next;
         ea_reg <= ea_next;
         st_reg <= st_next;
         done_reg <= done_next;
         inte_reg <= inte_next;
      end
   end

   // ***************************************************************
   // bus outputs
   // ***************************************************************
   assign o_mem_addr = mar_reg;
   assign o_mem_wdata = dbus_reg;
   assign o_mem_en = is_mem;
   assign o_mem_we = is_mem && (ucode.uw.kind == ics_pkg::MC_WRITE);
   assign o_data_oe = o_mem_we;
   assign o_dbin = is_mem && (ucode.uw.kind == ics_pkg::MC_READ);
   assign o_iaq = (state_reg == ics_pkg::ST_EXEC) && (ucode.uw.op == ics_pkg::U_FETCH);
   assign o_instr_done = done_reg;
   assign o_int_enter = inte_reg;

endmodule : ics_sequencer

/* ics_seq_props.sv */
/*
 * Checker of bus and sequencing properties of the cycle sequencer.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
module ics_seq_props (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_mem_ready,
   input wire logic [15:0] o_mem_addr,
   input wire logic [15:0] o_mem_wdata,
   input wire logic o_data_oe,
   input wire logic o_mem_en,
   input wire logic o_mem_we,
   input wire logic o_dbin,
   input wire logic o_iaq,
   input wire logic o_instr_done,
   input wire logic o_int_enter,
   input wire logic [3:0] o_clk_phase
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   a_phase_rotates: assert property (
      $past(i_arst_n) |-> o_clk_phase == {$past(o_clk_phase[2:0]), $past(o_clk_phase[3])})
      else $error("four-phase clock did not rotate");
   a_mem_two_min: assert property ($rose(o_mem_en) |=> o_mem_en)
      else $error("memory cycle shorter than two clocks");
   a_alu_no_bus: assert property (!o_mem_en |-> !o_mem_we && !o_dbin && !o_data_oe)
      else $error("bus strobe during alu cycle");
   a_alu_two_clocks: assert property ($fell(o_mem_en) |=> !o_mem_en)
      else $error("alu cycle shorter than two clocks");
   a_fetch_then_alu: assert property ($fell(o_iaq) |-> !o_mem_en)
      else $error("fetch not followed by alu cycle");
   a_fetch_is_read: assert property (o_iaq |-> o_mem_en && o_dbin && !o_mem_we)
      else $error("fetch is not a memory read");
   a_write_holds: assert property (
      o_mem_we && $past(o_mem_we) |-> $stable(o_mem_addr) && $stable(o_mem_wdata))
      else $error("write address or data moved");
   a_wait_extends: assert property (
      o_mem_en && !i_mem_ready && !$past(i_mem_ready) && !$past(i_mem_ready, 2)
      |=> o_mem_en && $stable(o_mem_addr))
      else $error("memory cycle ended without ready");
   a_done_then_next: assert property (
      o_instr_done |-> (o_iaq || !o_mem_en) ##1 !o_instr_done)
      else $error("done pulse wrong");
   a_int_vector: assert property (
      o_int_enter |-> o_mem_addr == ics_pkg::INT_VEC_PC && !$past(o_mem_en))
      else $error("interrupt entry not at vector");

   c_done: cover property (o_instr_done);
   c_int: cover property (o_int_enter);
   c_write: cover property ($rose(o_mem_we));
   c_wait: cover property (o_mem_en && !i_mem_ready);
endmodule : ics_seq_props

bind ics_sequencer ics_seq_props chk (
   .i_core_clk(i_core_clk),
   .i_arst_n(i_arst_n),
   .i_mem_ready(i_mem_ready),
   .o_mem_addr(o_mem_addr),
   .o_mem_wdata(o_mem_wdata),
   .o_data_oe(o_data_oe),
   .o_mem_en(o_mem_en),
   .o_mem_we(o_mem_we),
   .o_dbin(o_dbin),
   .o_iaq(o_iaq),
   .o_instr_done(o_instr_done),
   .o_int_enter(o_int_enter),
   .o_clk_phase(o_clk_phase)
);

/* ics_mem_model.sv */
/*
 * Behavioural program and data memory on the sequencer's bus.
 * Assumes word-aligned byte addresses; the bench preloads mem_q.
 */
`timescale 1ns/1ps
module ics_mem_model (
   input wire logic i_core_clk,
   input wire logic [15:0] i_mem_addr,
   input wire logic [15:0] i_mem_wdata,
   input wire logic i_mem_en,
   input wire logic i_mem_we,
   input wire logic [3:0] i_wait_clks,
   output logic o_mem_ready,
   output logic [15:0] o_mem_rdata
);
   logic [15:0] mem_q [0:32767];
   logic [15:0] last_addr = 16'h0000;
   logic last_we = 1'b0;
   int cnt = 0;

   initial begin
      o_mem_ready = 1'b1;
      o_mem_rdata = 16'h5A5A;
   end

   // changes land on the falling edge, away from the sampling edge
   always @(negedge i_core_clk) begin
      if (i_mem_en && i_mem_addr == last_addr && i_mem_we == last_we)
         cnt = cnt + 1;
      else
         cnt = 0;
      last_addr = i_mem_addr;
      last_we = i_mem_we;
      // slow memory holds ready low for the chosen clocks
      o_mem_ready <= (i_wait_clks == 4'h0) || (i_mem_en && cnt >= i_wait_clks);
      // an idle bus never keeps showing the last word
      if (i_mem_en && !i_mem_we)
         o_mem_rdata <= mem_q[i_mem_addr[15:1]];
      else
         o_mem_rdata <= ~o_mem_rdata;
   end

   always @(posedge i_core_clk) begin
      if (i_mem_en && i_mem_we && o_mem_ready)
         mem_q[i_mem_addr[15:1]] <= i_mem_wdata;
   end
endmodule : ics_mem_model

/* test_ics_sequencer.sv */
/*
 * Self-checking bench of the cycle sequencer running a small program.
 * Assumes the memory model and the bound checker.
 */
`timescale 1ns/1ps
module test_ics_sequencer;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic int_req = 1'b0;
   logic [3:0] wait_clks = 4'h0;
   logic ready, en, we, oe, dbin, iaq, done, int_enter;
   logic [15:0] rdata, addr, wdata;
   logic [3:0] phase;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int run_n = 0, mem_n = 0, len_q = 0, mem_c = 0, n_done = 0;
   logic run_q = 1'b0;
   logic [6:0] en_bits = 7'h00, we_bits = 7'h00, en_q, we_q;
   logic [15:0] am [0:31];
   logic [15:0] am_q [0:31];

   ics_sequencer uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_mem_ready(ready),
      .i_mem_rdata(rdata), .i_int_req(int_req), .o_mem_addr(addr), .o_mem_wdata(wdata),
      .o_data_oe(oe), .o_mem_en(en), .o_mem_we(we), .o_dbin(dbin), .o_iaq(iaq),
      .o_instr_done(done), .o_int_enter(int_enter), .o_clk_phase(phase));
   ics_mem_model u_mem (.i_core_clk(clk), .i_mem_addr(addr), .i_mem_wdata(wdata),
      .i_mem_en(en), .i_mem_we(we), .i_wait_clks(wait_clks), .o_mem_ready(ready),
      .o_mem_rdata(rdata));

   initial begin
      forever #12.5 clk = ~clk;
   end

   // ***************************************************************
   // monitor: per-instruction clock, memory and address trace
   // ***************************************************************
   always @(posedge clk) begin
      run_q <= arst_n;
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         print_verdict();
      end
   end
   always @(negedge clk) begin
      if (run_q && done === 1'b1) begin
         len_q = run_n;
         mem_c = mem_n;
         en_q = en_bits;
         we_q = we_bits;
         am_q = am;
         n_done++;
         run_n = 0;
         mem_n = 0;
      end
      if (run_q && run_n < 64) begin
         if (run_n % 2 == 0) begin
            en_bits = {en_bits[5:0], en};
            we_bits = {we_bits[5:0], we};
            am[run_n / 2] = addr;
         end
         run_n++;
         mem_n += int'(en);
      end
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check16
   task automatic chk_mem(input logic [15:0] a, input logic [15:0] exp);
      check16(u_mem.mem_q[a[15:1]], exp);
   endtask : chk_mem
   task automatic ld(input logic [15:0] a, input logic [15:0] d);
      u_mem.mem_q[a[15:1]] = d;
   endtask : ld
   task automatic wait_done();
      int seen;
      seen = n_done;
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         #1;
         if (n_done != seen) break;
      end
      check16({15'h0000, n_done != seen}, 16'h0001);
   endtask : wait_done
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset();
      check16(addr, 16'h0100);
      check16({12'h000, phase}, 16'h0001);
      check16({14'h0000, en, we}, 16'h0002);
   endtask : t_reset
   task automatic t_nop();
      wait_done();
      check16(16'(len_q), 16'h0004);
      check16(16'(mem_c), 16'h0002);
      check16(addr, 16'h0102);
   endtask : t_nop
   task automatic t_add();
      wait_done();
      check16(16'(len_q), 16'h000E);
      check16({9'h000, en_q}, 16'h0055);
      check16({9'h000, we_q}, 16'h0001);
      check16(am_q[2], 16'h0802);
      check16(am_q[4], 16'h0804);
      check16(am_q[5], 16'h0804);
      check16(am_q[6], 16'h0804);
      chk_mem(16'h0804, 16'h0023);
      check16(addr, 16'h0104);
   endtask : t_add
   task automatic t_abs();
      wait_done();
      check16(16'(len_q), 16'h000C);
      check16(16'(mem_c), 16'h0004);
      chk_mem(16'h0806, 16'h0005);
      wait_done();
      check16(16'(len_q), 16'h000E);
      check16(16'(mem_c), 16'h0006);
      chk_mem(16'h0808, 16'h0005);
   endtask : t_abs
   task automatic t_context_switch_branch_op();
      wait_done();
      check16(16'(len_q), 16'h001A);
      check16(16'(mem_c), 16'h000C);
      chk_mem(16'h0A1A, 16'h0800);
      chk_mem(16'h0A1C, 16'h010A);
      check16(addr, 16'h0200);
   endtask : t_context_switch_branch_op
   task automatic t_xop();
      wait_done();
      check16(16'(len_q), 16'h0024);
      check16(16'(mem_c), 16'h0010);
      chk_mem(16'h0C16, 16'h0A02);
      chk_mem(16'h0C1A, 16'h0A00);
      chk_mem(16'h0C1C, 16'h0202);
      check16(addr, 16'h0300);
   endtask : t_xop
   task automatic t_wait_int();
      logic seen;
      seen = 1'b0;
      wait_clks = 4'h2;
      int_req = 1'b1;
      wait_done();
      check16({15'h0000, len_q > 14}, 16'h0001);
      chk_mem(16'h0C04, 16'h0000);
      for (int i = 0; i < 20 && !seen; i++) begin
         @(negedge clk);
         #1;
         if (int_enter === 1'b1) begin
            seen = 1'b1;
            check16(addr, 16'h0004);
            int_req = 1'b0;
            wait_clks = 4'h0;
         end
      end
      check16({15'h0000, seen}, 16'h0001);
   endtask : t_wait_int

   initial begin
      for (int i = 0; i < 32768; i++) u_mem.mem_q[i] = 16'h0000;
      ld(16'h0102, 16'hA081);
      ld(16'h0104, 16'h0743);
      ld(16'h0106, 16'h0744);
      ld(16'h0108, 16'h0405);
      ld(16'h0200, 16'h2C41);
      ld(16'h0300, 16'hA081);
      ld(16'h0802, 16'h0019);
      ld(16'h0804, 16'h000A);
      ld(16'h0806, 16'h0005);
      ld(16'h0808, 16'hFFFB);
      ld(16'h080A, 16'h0A00);
      ld(16'h080C, 16'h0200);
      ld(16'h0044, 16'h0C00);
      ld(16'h0046, 16'h0300);
      ld(16'h0C02, 16'h0001);
      ld(16'h0C04, 16'hFFFF);
      repeat (2) @(negedge clk);
      t_reset();
      @(negedge clk);
      arst_n = 1'b1;
      t_nop();
      t_add();
      t_abs();
      t_context_switch_branch_op();
      t_xop();
      t_wait_int();
      print_verdict();
   end
endmodule : test_ics_sequencer
